//--- rtl/atsb_regs.svh
// Constants of the acquisition trigger, scan and buffer control block.
// Assumes an 8-bit host I/O port with a 5-bit port address.
`ifndef ATSB_REGS_SVH
`define ATSB_REGS_SVH

`define ATSB_ADDR_W 5
`define ATSB_OFS_STATUS 5'h08
`define ATSB_OFS_TRIG 5'h0c
`define ATSB_OFS_FORMAT 5'h0d
`define ATSB_OFS_MUX 5'h10
`define ATSB_OFS_GAIN 5'h11
`define ATSB_OFS_BUFCTL 5'h12
`define ATSB_OFS_RES_LO 5'h13
`define ATSB_OFS_RES_HI 5'h14
`define ATSB_OFS_BUF_LO 5'h15
`define ATSB_OFS_BUF_HI 5'h16

`define ATSB_MODE_SCAN 0
`define ATSB_MODE_ITYPE 1
`define ATSB_MODE_EXT 2
`define ATSB_MODE_DMA 3
`define ATSB_FMT_STYPE 2
`define ATSB_FMT_BUFEN 3
`define ATSB_BUFCTL_EN 0

`define ATSB_MODE_RST 4'h0
`define ATSB_MUX_RST 4'h0
`define ATSB_GAIN_RST 2'h0
`define ATSB_RESULT_RST 16'h0000

`define ATSB_BUF_DEPTH 1024
`define ATSB_DATA_W 16

`endif

//--- rtl/atsb_pkg.sv
// Types of the acquisition trigger, scan and buffer control block.
// Assumes the constants header is compiled alongside.
package atsb_pkg;

	typedef enum logic [0:0] {
		ATSB_IDLE = 1'b0,
		ATSB_BUSY = 1'b1
	} atsb_conv_t;

	typedef enum logic [1:0] {
		ATSB_GAIN1 = 2'h0,
		ATSB_GAIN2 = 2'h1,
		ATSB_GAIN4 = 2'h2,
		ATSB_GAIN8 = 2'h3
	} atsb_gain_t;

	typedef struct packed {
		logic dmaEnable;
		logic externalTriggerSelect;
		logic internalTriggerType;
		logic autoScanEnable;
	} atsb_mode_t;

	typedef struct packed {
		atsb_mode_t mode;
		logic [3:0] muxChan;
		atsb_gain_t gain;
		logic bufferEnable;
		logic [3:0] scanChan;
		atsb_conv_t conv;
		logic [15:0] result;
		logic [2:0] extSync;
		logic [1:0] typeSync;
		logic pacerLast;
		logic convStart;
		logic [3:0] convChan;
		atsb_gain_t convGain;
		logic [7:0] rdData;
	} atsb_state_t;

endpackage

//--- rtl/atsb_ctrl.sv
// Trigger selection, auto-scan channel stepping, result register and sample buffer.
// Assumes a host I/O port on ref_clk with one-cycle read and write strobes, a timer
// pacer pulse and converter handshake on ref_clk, and asynchronous trigger and jumper pins.
`timescale 1ns/10ps
`include "atsb_regs.svh"

////////////////////////////////////////////////////////////////////////////////
module atsb_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic flush,
	// Fill side
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	// Drain side
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData,
	output logic [$clog2(DEPTH):0] count
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW:0] wrPtr;
		logic [AW:0] rdPtr;
	} atsb_fptr_t;

	atsb_fptr_t ptr_reg;
	atsb_fptr_t ptr_next;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push;
	logic pop;

	assign count = ptr_reg.wrPtr - ptr_reg.rdPtr;
	assign inReady = (count != (AW+1)'(DEPTH)) && !flush;
	assign outValid = (count != '0) && !flush;
	assign outData = mem[ptr_reg.rdPtr[AW-1:0]];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	always_comb begin
		ptr_next = ptr_reg;
		if (flush) begin
			ptr_next = '0;
		end else begin
			if (push) begin
				ptr_next.wrPtr = ptr_reg.wrPtr + 1'b1;
			end
			if (pop) begin
				ptr_next.rdPtr = ptr_reg.rdPtr + 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			ptr_reg <= '0;
		end else begin
			ptr_reg <= ptr_next;
		end
		if (push) begin
			mem[ptr_reg.wrPtr[AW-1:0]] <= inData;
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////////
module atsb_ctrl #(
	parameter int BUF_DEPTH = `ATSB_BUF_DEPTH
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// Host I/O port
	input wire logic [`ATSB_ADDR_W-1:0] ioAddr,
	input wire logic ioRd,
	input wire logic ioWr,
	input wire logic [7:0] ioWrData,
	output logic [7:0] ioRdData,
	// Pins
	input wire logic externalTriggerInput,
	input wire logic signalTypeJumper,
	// Timer pacer
	input wire logic pacerPulse,
	// Converter
	output logic convStart,
	output logic [3:0] convChan,
	output logic [1:0] convGain,
	input wire logic convDone,
	input wire logic [`ATSB_DATA_W-1:0] convData
);
	localparam int CW = $clog2(BUF_DEPTH) + 1;

	atsb_pkg::atsb_state_t s_reg;
	atsb_pkg::atsb_state_t s_next;
	logic singleEnded;
	logic [3:0] selChan;
	logic [3:0] endChan;
	logic [3:0] statusChan;
	logic swTrig;
	logic pacerTrig;
	logic external_trigger_input;
	logic trigPulse;
	logic startNow;
	logic doneNow;
	logic bufInValid;
	logic bufInReady;
	logic bufOutValid;
	logic bufPop;
	logic [`ATSB_DATA_W-1:0] bufOutData;
	logic [CW-1:0] bufCount;

	function automatic logic hit(input logic [`ATSB_ADDR_W-1:0] a,
			input logic [`ATSB_ADDR_W-1:0] ofs);
		return a == ofs;
	endfunction

	atsb_fifo #(.WIDTH(`ATSB_DATA_W), .DEPTH(BUF_DEPTH)) u_buf (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.flush(!s_reg.bufferEnable),
		.inValid(bufInValid),
		.inReady(bufInReady),
		.inData(convData),
		.outValid(bufOutValid),
		.outReady(bufPop),
		.outData(bufOutData),
		.count(bufCount)
	);

	// Jumper level, synchronised; 1 means single-ended
	assign singleEnded = s_reg.typeSync[1];
	// Differential mode only reaches eight channels
	assign selChan = s_reg.mode.autoScanEnable ? s_reg.scanChan : s_reg.muxChan;
	assign endChan = singleEnded ? s_reg.muxChan : {1'b0, s_reg.muxChan[2:0]};
	assign statusChan = {selChan[3] | !singleEnded, selChan[2:0]};

	assign swTrig = ioRd && hit(ioAddr, `ATSB_OFS_TRIG) && !s_reg.mode.externalTriggerSelect
		&& !s_reg.mode.internalTriggerType;
	assign pacerTrig = !s_reg.mode.externalTriggerSelect && s_reg.mode.internalTriggerType
		&& pacerPulse && !s_reg.pacerLast;
	// Edge taken from the second and third stages only
	assign external_trigger_input = s_reg.mode.externalTriggerSelect && s_reg.extSync[1]
		&& !s_reg.extSync[2];
	assign trigPulse = swTrig || pacerTrig || external_trigger_input;
	// A trigger during a conversion is ignored and does not step the scan
	assign startNow = trigPulse && (s_reg.conv == atsb_pkg::ATSB_IDLE);
	assign doneNow = convDone && (s_reg.conv == atsb_pkg::ATSB_BUSY);
	// Full buffer refuses the push, so the sample is dropped
	assign bufInValid = doneNow && s_reg.bufferEnable;
	assign bufPop = ioRd && hit(ioAddr, `ATSB_OFS_BUF_HI);

	always_comb begin
		s_next = s_reg;
		s_next.extSync = {s_reg.extSync[1:0], externalTriggerInput};
		s_next.typeSync = {s_reg.typeSync[0], signalTypeJumper};
		s_next.pacerLast = pacerPulse;
		s_next.convStart = startNow;
		if (ioWr) begin
			case (ioAddr)
				`ATSB_OFS_TRIG: begin
					s_next.mode = atsb_pkg::atsb_mode_t'(ioWrData[3:0]);
				end
				`ATSB_OFS_MUX: begin
					s_next.muxChan = ioWrData[3:0];
				end
				`ATSB_OFS_GAIN: begin
					s_next.gain = atsb_pkg::atsb_gain_t'(ioWrData[1:0]);
				end
				`ATSB_OFS_BUFCTL: begin
					s_next.bufferEnable = ioWrData[`ATSB_BUFCTL_EN];
				end
				default: begin
				end
			endcase
		end
		if (!s_reg.mode.autoScanEnable) begin
			s_next.scanChan = 4'h0;
		end else if (startNow) begin
			s_next.scanChan = (s_reg.scanChan >= endChan) ? 4'h0 : s_reg.scanChan + 4'h1;
		end
		case (s_reg.conv)
			atsb_pkg::ATSB_IDLE: begin
				if (startNow) begin
					s_next.conv = atsb_pkg::ATSB_BUSY;
					s_next.convChan = singleEnded ? selChan : {1'b0, selChan[2:0]};
					s_next.convGain = s_reg.gain;
				end
			end
			atsb_pkg::ATSB_BUSY: begin
				if (convDone) begin
					s_next.conv = atsb_pkg::ATSB_IDLE;
					s_next.result = convData;
				end
			end
			default: begin
				s_next.conv = atsb_pkg::ATSB_IDLE;
			end
		endcase
		s_next.rdData = 8'h00;
		if (ioRd) begin
			case (ioAddr)
				`ATSB_OFS_STATUS: begin
					s_next.rdData = {s_reg.conv == atsb_pkg::ATSB_IDLE, bufInReady,
						bufCount < CW'(BUF_DEPTH / 2), bufOutValid, statusChan};
				end
				`ATSB_OFS_TRIG: begin
					s_next.rdData = {4'h0, s_reg.mode};
				end
				`ATSB_OFS_FORMAT: begin
					s_next.rdData[`ATSB_FMT_BUFEN] = s_reg.bufferEnable;
					s_next.rdData[`ATSB_FMT_STYPE] = singleEnded;
				end
				`ATSB_OFS_MUX: begin
					s_next.rdData = {4'h0, s_reg.muxChan};
				end
				`ATSB_OFS_GAIN: begin
					s_next.rdData = {6'h00, s_reg.gain};
				end
				`ATSB_OFS_BUFCTL: begin
					s_next.rdData = {7'h00, s_reg.bufferEnable};
				end
				`ATSB_OFS_RES_LO: begin
					s_next.rdData = s_reg.result[7:0];
				end
				`ATSB_OFS_RES_HI: begin
					s_next.rdData = s_reg.result[15:8];
				end
				`ATSB_OFS_BUF_LO: begin
					s_next.rdData = bufOutData[7:0];
				end
				`ATSB_OFS_BUF_HI: begin
					s_next.rdData = bufOutData[15:8];
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			s_reg <= '0;
			// Sync chains keep sampling through reset, so the jumper level is settled at release
			s_reg.extSync <= s_next.extSync;
			s_reg.typeSync <= s_next.typeSync;
			s_reg.mode <= `ATSB_MODE_RST;
			s_reg.muxChan <= `ATSB_MUX_RST;
			s_reg.gain <= atsb_pkg::atsb_gain_t'(`ATSB_GAIN_RST);
			s_reg.result <= `ATSB_RESULT_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	assign ioRdData = s_reg.rdData;
	assign convStart = s_reg.convStart;
	assign convChan = s_reg.convChan;
	assign convGain = s_reg.convGain;

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);

	sequence s_ext_rise;
		s_reg.mode.externalTriggerSelect && s_reg.extSync[1] && !s_reg.extSync[2];
	endsequence
	sequence s_sw_read;
		ioRd && hit(ioAddr, `ATSB_OFS_TRIG) && !s_reg.mode.externalTriggerSelect
			&& !s_reg.mode.internalTriggerType;
	endsequence

	a_ext_edge_start: assert property (
		(s_ext_rise and (s_reg.conv == atsb_pkg::ATSB_IDLE)) |=> convStart ##1 !convStart)
		else $error("external rising edge did not give one start pulse");
	a_sw_read_start: assert property (
		(s_sw_read and (s_reg.conv == atsb_pkg::ATSB_IDLE)) |=> convStart)
		else $error("software trigger read did not start a conversion");
	a_start_cause: assert property (
		convStart |-> $past(trigPulse) && $past(s_reg.conv) == atsb_pkg::ATSB_IDLE)
		else $error("conversion started without a trigger");
	a_ext_ignores_sw: assert property (
		(s_reg.mode.externalTriggerSelect && !external_trigger_input) |=> !convStart)
		else $error("start without external edge in external mode");
	a_result_hold: assert property (
		(s_reg.conv == atsb_pkg::ATSB_BUSY && !convDone) |=> $stable(s_reg.result))
		else $error("result changed during conversion");
	a_result_load: assert property (
		doneNow |=> s_reg.result == $past(convData) && s_reg.conv == atsb_pkg::ATSB_IDLE)
		else $error("result not loaded at end of conversion");
	a_buffer_push: assert property (
		(bufInValid && bufInReady && !bufPop) |=> bufCount == $past(bufCount) + 1'b1)
		else $error("enabled buffer missed a result");
	a_buffer_full_drop: assert property (
		(bufCount == CW'(BUF_DEPTH) && !bufPop) |=> bufCount == CW'(BUF_DEPTH))
		else $error("full buffer took a sample");
	a_buffer_off: assert property (
		!s_reg.bufferEnable |=> bufCount == '0 && !bufOutValid)
		else $error("disabled buffer not held empty");
	a_scan_wrap: assert property (
		(s_reg.mode.autoScanEnable && startNow && s_reg.scanChan >= endChan)
			|=> s_reg.scanChan == 4'h0)
		else $error("scan did not wrap to channel 0");
	a_fixed_chan: assert property (
		(!s_reg.mode.autoScanEnable && startNow && singleEnded) |=> convChan == $past(s_reg.muxChan))
		else $error("fixed channel not converted");
	a_diff_upper: assert property (
		(ioRd && hit(ioAddr, `ATSB_OFS_STATUS) && !singleEnded) |=> ioRdData[3])
		else $error("upper channel bit clear in differential mode");
endmodule

//--- bench/atsb_conv_model.sv
// Behavioural converter that answers the control block's start pulses.
// Assumes convStart is a one-cycle pulse on ref_clk with channel and gain held.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module atsb_conv_model #(
	parameter int LAT = 6
) (
	// Clock
	input wire logic ref_clk,
	// Control side
	input wire logic convStart,
	input wire logic [3:0] convChan,
	input wire logic [1:0] convGain,
	output logic convDone,
	output logic [15:0] convData
);
	int cnt;
	logic [15:0] val;
	initial begin
		cnt = 0;
		convDone = 1'b0;
		val = 16'h0000;
	end
	// Result carries channel and gain so the bench can see what was converted
	always @(posedge ref_clk) begin
		convDone <= 1'b0;
		if (convStart === 1'b1) begin
			cnt <= LAT;
			val <= {8'h5a, 2'b00, convGain, convChan};
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
			if (cnt == 1) begin
				convDone <= 1'b1;
			end
		end
	end
	// Outside the done cycle the data bus is not held: show the inverse
	assign convData = convDone ? val : ~val;
endmodule

//--- bench/atsb_ctrl_test.sv
// Self-checking bench of the trigger, scan and buffer control block.
// Assumes the constants header is on the include path and an 8-entry buffer.
`timescale 1ns/10ps
`include "atsb_regs.svh"
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin failCount++; \
	$display("ERROR %s expected %h seen %h", nm, ex, gt); end end

////////////////////////////////////////////////////////////////////////////////
module atsb_ctrl_test;
	localparam int DEPTH = 8;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [4:0] ioAddr = 5'h00;
	logic ioRd = 1'b0;
	logic ioWr = 1'b0;
	logic [7:0] ioWrData = 8'h00;
	logic [7:0] ioRdData;
	logic externalTriggerInput = 1'b0;
	logic signalTypeJumper = 1'b1;
	logic pacerPulse = 1'b0;
	logic convStart, convDone;
	logic [3:0] convChan;
	logic [1:0] convGain;
	logic [15:0] convData;
	logic [7:0] d;
	int checked = 0;
	int failCount = 0;
	int starts = 0;
	int s0;

	always #25 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (convStart === 1'b1) starts++;

	atsb_ctrl #(.BUF_DEPTH(DEPTH)) atsb_ctrl_inst (.ref_clk(ref_clk), .reset_n(reset_n),
		.ioAddr(ioAddr), .ioRd(ioRd), .ioWr(ioWr), .ioWrData(ioWrData),
		.ioRdData(ioRdData), .externalTriggerInput(externalTriggerInput),
		.signalTypeJumper(signalTypeJumper), .pacerPulse(pacerPulse),
		.convStart(convStart), .convChan(convChan), .convGain(convGain),
		.convDone(convDone), .convData(convData));
	atsb_conv_model atsb_conv_model_inst (.ref_clk(ref_clk), .convStart(convStart),
		.convChan(convChan), .convGain(convGain), .convDone(convDone), .convData(convData));

	////////////////////////////////////////////////////////////////////////////////
	task automatic io_wr(input logic [4:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		#1 ioAddr = a; ioWrData = v; ioWr = 1'b1;
		@(posedge ref_clk);
		#1 ioWr = 1'b0;
	endtask
	task automatic io_rd(input logic [4:0] a, output logic [7:0] v);
		@(posedge ref_clk);
		#1 ioAddr = a; ioRd = 1'b1;
		@(posedge ref_clk);
		#1 ioRd = 1'b0;
		v = ioRdData;
	endtask
	task automatic wait_done;
		int n;
		n = 0;
		while (convDone !== 1'b1 && n < 100) begin
			@(posedge ref_clk);
			#1 n++;
		end
		repeat (2) @(posedge ref_clk);
		if (n >= 100) begin
			failCount++;
			$display("ERROR conversion end expected 1 seen 0");
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic sw_conv;
		io_rd(`ATSB_OFS_TRIG, d);
		wait_done();
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic test_reset;
		io_rd(`ATSB_OFS_STATUS, d); `CHK("status", 8'ha0, d)
		io_rd(`ATSB_OFS_FORMAT, d); `CHK("format", 8'h04, d)
		io_rd(5'h1f, d); `CHK("unmapped", 8'h00, d)
		$display("test reset done");
	endtask
	task automatic test_single;
		io_wr(`ATSB_OFS_MUX, 8'h05);
		for (int g = 0; g < 4; g++) begin
			io_wr(`ATSB_OFS_GAIN, 8'(g));
			s0 = starts;
			sw_conv();
			`CHK("starts", s0 + 1, starts)
			io_rd(`ATSB_OFS_RES_LO, d); `CHK("res lo", {2'b00, 2'(g), 4'h5}, d)
			io_rd(`ATSB_OFS_RES_HI, d); `CHK("res hi", 8'h5a, d)
			io_rd(`ATSB_OFS_STATUS, d); `CHK("chan", 4'h5, d[3:0])
		end
		$display("test single done");
	endtask
	task automatic test_scan;
		io_wr(`ATSB_OFS_BUFCTL, 8'h01);
		io_wr(`ATSB_OFS_GAIN, 8'h02);
		io_wr(`ATSB_OFS_MUX, 8'h02);
		io_wr(`ATSB_OFS_TRIG, 8'h01);
		for (int i = 0; i < 4; i++) begin
			io_rd(`ATSB_OFS_STATUS, d); `CHK("scan chan", 4'(i % 3), d[3:0])
			sw_conv();
		end
		for (int i = 0; i < 4; i++) begin
			io_rd(`ATSB_OFS_BUF_LO, d); `CHK("buf lo", {4'h2, 4'(i % 3)}, d)
			io_rd(`ATSB_OFS_BUF_HI, d); `CHK("buf hi", 8'h5a, d)
		end
		io_rd(`ATSB_OFS_FORMAT, d); `CHK("format", 8'h0c, d)
		io_wr(`ATSB_OFS_TRIG, 8'h00);
		io_rd(`ATSB_OFS_STATUS, d); `CHK("scan off", 4'h2, d[3:0])
		$display("test scan done");
	endtask
	task automatic test_full;
		io_wr(`ATSB_OFS_GAIN, 8'h00);
		for (int i = 0; i < DEPTH + 2; i++) begin
			io_wr(`ATSB_OFS_MUX, 8'(i));
			sw_conv();
		end
		io_rd(`ATSB_OFS_STATUS, d); `CHK("full", 4'h9, d[7:4])
		// Host drains everything that was kept
		for (int i = 0; i < DEPTH; i++) begin
			io_rd(`ATSB_OFS_BUF_LO, d); `CHK("kept", 8'(i), d)
			io_rd(`ATSB_OFS_BUF_HI, d);
		end
		io_rd(`ATSB_OFS_STATUS, d); `CHK("empty", 4'he, d[7:4])
		io_wr(`ATSB_OFS_BUFCTL, 8'h00);
		$display("test full done");
	endtask
	task automatic test_hw_trig;
		io_wr(`ATSB_OFS_TRIG, 8'h02);
		s0 = starts;
		io_rd(`ATSB_OFS_TRIG, d); `CHK("mode", 8'h02, d)
		idle(12);
		`CHK("sw in pacer", s0, starts)
		pacerPulse = 1'b1;
		idle(1);
		pacerPulse = 1'b0;
		wait_done();
		`CHK("pacer", s0 + 1, starts)
		io_wr(`ATSB_OFS_TRIG, 8'h0e);
		io_rd(`ATSB_OFS_TRIG, d); `CHK("ext mode", 8'h0e, d)
		externalTriggerInput = 1'b1;
		wait_done();
		`CHK("ext rise", s0 + 2, starts)
		idle(10);
		externalTriggerInput = 1'b0;
		pacerPulse = 1'b1;
		idle(1);
		pacerPulse = 1'b0;
		idle(12);
		`CHK("ext fall", s0 + 2, starts)
		io_wr(`ATSB_OFS_TRIG, 8'h00);
		$display("test hardware triggers done");
	endtask
	task automatic test_diff;
		signalTypeJumper = 1'b0;
		idle(4);
		io_rd(`ATSB_OFS_FORMAT, d); `CHK("format", 8'h00, d)
		io_wr(`ATSB_OFS_MUX, 8'h01);
		io_rd(`ATSB_OFS_STATUS, d); `CHK("diff chan", 4'h9, d[3:0])
		io_wr(`ATSB_OFS_MUX, 8'h09);
		sw_conv();
		io_rd(`ATSB_OFS_RES_LO, d); `CHK("diff res", 8'h01, d)
		$display("test differential done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checked, failCount);
		if (failCount == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		repeat (5) @(posedge ref_clk);
		#1 reset_n = 1'b1;
		test_reset();
		test_single();
		test_scan();
		test_full();
		test_hw_trig();
		test_diff();
		tally_and_finish();
	end
	// Whole run needs a few hundred cycles; twenty thousand means a hang
	initial begin
		#1000000;
		failCount++;
		tally_and_finish();
	end
endmodule
